// *** hdl/smarx_regs.sv ***
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "smarx_cfg.svh"
// Summary of operation
// - sub-carrier mode: frequency code 00..11 gives fc/64, fc/32, fc/16, fc/8
// - bpsk mode: code 00..10 gives fc/16, fc/8, fc/4; 11 unused
// - pulse code 00..11 gives 1 (bpsk only), 2, 4, 8 pulses per report
// - tx period code 000..110 gives fc/128 down to fc/2; 111 unused
// - all three registers load defaults at reset and set-default command
// - no-crc bit makes receiver accept frames without crc check
// - crc skipped automatically for reqa, wupa command and anticollision
// - crc-to-fifo bit keeps check but passes crc bytes on
// - modulation bit: 0 ook, 1 am; preset command sets it, write overrides
// - field detector enable activates external field detector
// - ook tristate bit floats rf output driver during ook modulation
// - tolerance bit defaults to one and relaxes decoders
// - two-bit n value for field-on commands
// - channel select: 0 am, 1 pm; one enabled or manual framing choice
// - am demodulator: 0 peak, 1 mixer; very high bit rate forces mixer
module smarx_regs (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // commands and mode inputs from the framing logic
   input wire logic set_default_in,
   input wire logic analog_preset_in,
   input wire logic preset_mod_am_in,
   input wire logic bpsk_mode_in,
   input wire logic tx_reqa_wupa_in,
   input wire logic anticoll_in,
   input wire logic ook_active_in,
   input wire logic am_en_in,
   input wire logic pm_en_in,
   input wire logic very_high_bit_rate_in,
   input wire logic carrier_tick_in,
   // decoded controls
   output logic [3:0] sub_carrier_log2_out,
   output logic [3:0] pulses_out,
   output logic pulse_cfg_bad_out,
   output logic freq_cfg_bad_out,
   output logic tx_period_bad_out,
   output logic tx_mod_tick_out,
   output logic rx_crc_check_out,
   output logic rx_crc_to_fifo_out,
   output logic modulation_type_sel_out,
   output logic field_detector_enable_out,
   output logic rf_output_driver_oe_b_out,
   output logic rx_tolerant_out,
   output logic [1:0] nfc_n_out,
   output logic rx_channel_select_out,
   output logic am_ch_on_out,
   output logic pm_ch_on_out,
   output logic am_mixer_out,
   output logic [5:0] filter_cfg_out
);
   // ==========================================================
   // bus decode
   wire sel_stream = (addr_in == `SMARX_ADDR_STREAM);
   wire sel_aux = (addr_in == `SMARX_ADDR_AUX);
   wire sel_rx1 = (addr_in == `SMARX_ADDR_RXCFG1);
   logic [7:0] stream_q;
   logic [7:0] aux_q;
   logic [7:0] rx1_q;
   smarx_bus_if bus_stream ();
   smarx_bus_if bus_aux ();
   smarx_bus_if bus_rx1 ();

   // register write strobes, set-default reloads all
   assign bus_stream.wr_en = wr_in & sel_stream;
   assign bus_stream.load_def = set_default_in;
   assign bus_stream.wdata = wdata_in;
   assign bus_rx1.wr_en = wr_in & sel_rx1;
   assign bus_rx1.load_def = set_default_in;
   assign bus_rx1.wdata = wdata_in;
   // aux: preset command updates modulation bit; a same-cycle write overrides
   wire aux_wr = wr_in & sel_aux;
   wire [7:0] aux_preset = {aux_q[7:6], preset_mod_am_in, aux_q[4:0]};
   assign bus_aux.wr_en = aux_wr | analog_preset_in;
   assign bus_aux.load_def = set_default_in;
   assign bus_aux.wdata = aux_wr ? wdata_in : aux_preset;

   smarx_reg8 #(.RESET_VAL(`SMARX_RST_STREAM)) u_stream (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .bus(bus_stream),
      .val_out(stream_q)
   );
   smarx_reg8 #(.RESET_VAL(`SMARX_RST_AUX)) u_aux (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .bus(bus_aux),
      .val_out(aux_q)
   );
   smarx_reg8 #(.RESET_VAL(`SMARX_RST_RXCFG1)) u_rx1 (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .bus(bus_rx1),
      .val_out(rx1_q)
   );

   // ==========================================================
   // field extraction
   wire [1:0] scf = stream_q[`SMARX_SCF_LSB+:2];
   wire [1:0] scp = stream_q[`SMARX_SCP_LSB+:2];
   wire [2:0] stx = stream_q[`SMARX_STX_LSB+:3];

   // sub-carrier period as log2 of fc divisor
   wire [3:0] sc_log2_sub = 4'(6 - scf);
   wire [3:0] sc_log2_bpsk = 4'(4 - scf);
   wire [3:0] sc_log2_d = bpsk_mode_in ? sc_log2_bpsk : sc_log2_sub;
   wire freq_bad_d = bpsk_mode_in & (scf == 2'b11);
   // pulses per report: 1,2,4,8; single pulse only legal for bpsk
   wire [3:0] pulses_d = 4'(1 << scp);
   wire pulse_bad_d = ~bpsk_mode_in & (scp == 2'b00);
   // tx modulator period log2 is 7 - code
   wire [2:0] stx_log2 = 3'(7 - stx);
   wire stx_bad_d = (stx == 3'b111);
   wire tx_pulse;

   // unused code gives no tick rather than a bogus period
   smarx_div #(.WIDTH(8)) u_txdiv (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(carrier_tick_in & ~stx_bad_d),
      .log2_in(stx_log2),
      .pulse_out(tx_pulse)
   );

   // crc handling: skip on bit, reqa/wupa or anticollision
   wire crc_check_d = ~aux_q[`SMARX_NO_CRC_BIT] & ~tx_reqa_wupa_in & ~anticoll_in;
   wire crc_fifo_d = aux_q[`SMARX_CRC_FIFO_BIT] & crc_check_d;
   // rf driver floats only while ook modulation active
   wire tri_d = aux_q[`SMARX_OOK_TRI_BIT] & ook_active_in &
                (aux_q[`SMARX_MOD_BIT] == smarx_pkg::SMARX_MOD_OOK);
   // channel enables: single enabled channel chosen by select bit
   wire one_ch = am_en_in ^ pm_en_in;
   wire both_ch = am_en_in & pm_en_in;
   wire chsel = rx1_q[`SMARX_CHSEL_BIT];
   wire am_on_d = (am_en_in | pm_en_in) & (both_ch | (one_ch & ~chsel));
   wire pm_on_d = (am_en_in | pm_en_in) & (both_ch | (one_ch & chsel));
   // very high bit rate forces the mixer
   wire mixer_d = rx1_q[`SMARX_AMD_BIT] | very_high_bit_rate_in;

   // read mux, unmapped reads zero
   wire [7:0] rd_mux = sel_stream ? stream_q :
                       sel_aux ? aux_q :
                       sel_rx1 ? rx1_q : 8'h00;

   // ==========================================================
   // registered outputs; one cycle later than field changes
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= 8'h00;
         sub_carrier_log2_out <= 4'h6;
         pulses_out <= 4'h1;
         pulse_cfg_bad_out <= 1'b0;
         freq_cfg_bad_out <= 1'b0;
         tx_period_bad_out <= 1'b0;
         tx_mod_tick_out <= 1'b0;
      end else begin
         rdata_out <= rd_in ? rd_mux : 8'h00;
         sub_carrier_log2_out <= sc_log2_d;
         pulses_out <= pulses_d;
         pulse_cfg_bad_out <= pulse_bad_d;
         freq_cfg_bad_out <= freq_bad_d;
         tx_period_bad_out <= stx_bad_d;
         tx_mod_tick_out <= tx_pulse;
      end
   end

   // auxiliary controls
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_crc_check_out <= 1'b1;
         rx_crc_to_fifo_out <= 1'b0;
         modulation_type_sel_out <= 1'b0;
         field_detector_enable_out <= 1'b0;
         rf_output_driver_oe_b_out <= 1'b0;
         rx_tolerant_out <= 1'b1;
         nfc_n_out <= 2'b00;
      end else begin
         rx_crc_check_out <= crc_check_d;
         rx_crc_to_fifo_out <= crc_fifo_d;
         modulation_type_sel_out <= aux_q[`SMARX_MOD_BIT];
         field_detector_enable_out <= aux_q[`SMARX_FD_BIT];
         rf_output_driver_oe_b_out <= tri_d;
         rx_tolerant_out <= aux_q[`SMARX_TOL_BIT];
         nfc_n_out <= aux_q[`SMARX_NFCN_LSB+:2];
      end
   end

   // receiver controls
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_channel_select_out <= 1'b0;
         am_ch_on_out <= 1'b0;
         pm_ch_on_out <= 1'b0;
         am_mixer_out <= 1'b0;
         filter_cfg_out <= 6'h00;
      end else begin
         rx_channel_select_out <= chsel;
         am_ch_on_out <= am_on_d;
         pm_ch_on_out <= pm_on_d;
         am_mixer_out <= mixer_d;
         filter_cfg_out <= rx1_q[`SMARX_FILT_LSB+:6];
      end
   end

   // ==========================================================
   // checks
   // single-cycle conditions: a plain aux write, a preset with no write beside it
   sequence s_aux_write;
      aux_wr && !set_default_in;
   endsequence
   sequence s_preset_only;
      analog_preset_in && !aux_wr && !set_default_in;
   endsequence

   // defaults
   a_default_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      set_default_in |=> (aux_q == `SMARX_RST_AUX) && (stream_q == `SMARX_RST_STREAM)
      && (rx1_q == `SMARX_RST_RXCFG1))
      else $error("defaults not loaded");

   a_tol_default: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      set_default_in |=> ##1 rx_tolerant_out)
      else $error("tolerance default lost");

   // stream mode decode
   a_sub_freq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !bpsk_mode_in |=> sub_carrier_log2_out == 4'(6 - $past(scf)))
      else $error("sub-carrier divisor wrong");

   a_bpsk_freq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      bpsk_mode_in |=> sub_carrier_log2_out == 4'(4 - $past(scf)))
      else $error("bpsk divisor wrong");

   a_freq_bad: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bpsk_mode_in && (scf == 2'b11)) |=> freq_cfg_bad_out)
      else $error("unused bpsk code not flagged");

   a_pulse_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (scp == 2'b11) |=> pulses_out == 4'h8)
      else $error("pulse count wrong");

   a_pulse_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (scp == 2'b00) |=> pulses_out == 4'h1)
      else $error("single pulse count wrong");

   a_pulse_bad: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (!bpsk_mode_in && (scp == 2'b00)) |=> pulse_cfg_bad_out)
      else $error("single pulse outside bpsk not flagged");

   a_tx_unused: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (stx == 3'b111) [*3] |=> !tx_mod_tick_out)
      else $error("tick on unused period");

   a_tx_bad: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (stx == 3'b111) |=> tx_period_bad_out)
      else $error("unused period not flagged");

   // shortest period is two carrier ticks, so a tick never repeats at once
   a_tick_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      tx_mod_tick_out |=> !tx_mod_tick_out)
      else $error("modulator tick too long");

   // crc handling
   a_crc_skip: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (tx_reqa_wupa_in || anticoll_in || aux_q[7]) |=> !rx_crc_check_out)
      else $error("crc not skipped");

   a_crc_keep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (!aux_q[`SMARX_NO_CRC_BIT] && !tx_reqa_wupa_in && !anticoll_in) |=> rx_crc_check_out)
      else $error("crc check dropped");

   a_crc_fifo: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      rx_crc_to_fifo_out |-> rx_crc_check_out)
      else $error("crc to fifo without check");

   a_crc_fifo_on: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (aux_q[`SMARX_CRC_FIFO_BIT] && crc_check_d) |=> rx_crc_to_fifo_out)
      else $error("crc bytes not passed on");

   // auxiliary controls, two cycles after the write
   a_mod_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_aux_write |=> ##1 modulation_type_sel_out == $past(wdata_in[`SMARX_MOD_BIT], 2))
      else $error("modulation write lost");

   a_mod_preset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_preset_only |=> ##1 modulation_type_sel_out == $past(preset_mod_am_in, 2))
      else $error("modulation preset lost");

   a_fd_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_aux_write |=> ##1 field_detector_enable_out == $past(wdata_in[`SMARX_FD_BIT], 2))
      else $error("field detector enable lost");

   a_tol_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_aux_write |=> ##1 rx_tolerant_out == $past(wdata_in[`SMARX_TOL_BIT], 2))
      else $error("tolerance write lost");

   a_nfc_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_aux_write |=> ##1 nfc_n_out == $past(wdata_in[`SMARX_NFCN_LSB+:2], 2))
      else $error("n value write lost");

   // rf driver
   a_ook_tri: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      rf_output_driver_oe_b_out |-> $past(ook_active_in) && $past(aux_q[3]))
      else $error("driver floated outside ook");

   a_ook_float: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (aux_q[`SMARX_OOK_TRI_BIT] && ook_active_in && !aux_q[`SMARX_MOD_BIT])
      |=> rf_output_driver_oe_b_out)
      else $error("driver not floated in ook");

   a_am_drive: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      aux_q[`SMARX_MOD_BIT] |=> !rf_output_driver_oe_b_out)
      else $error("driver floated in am");

   // receiver
   a_mixer_very_high_bit_rate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      very_high_bit_rate_in |=> am_mixer_out)
      else $error("mixer not forced");

   a_mixer_reg: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      rx1_q[`SMARX_AMD_BIT] |=> am_mixer_out)
      else $error("mixer select ignored");

   a_chan_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (am_en_in && !pm_en_in && !chsel) |=> am_ch_on_out && !pm_ch_on_out)
      else $error("channel choice wrong");

   a_chan_pm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (pm_en_in && !am_en_in && chsel) |=> pm_ch_on_out && !am_ch_on_out)
      else $error("pm channel choice wrong");

   // read port: data for one cycle only
   a_read_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data outside read cycle");

   a_read_aux: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (rd_in && sel_aux) |=> rdata_out == $past(aux_q))
      else $error("aux read data wrong");
endmodule // smarx_regs

// *** include/smarx_cfg.svh ***
`ifndef SMARX_CFG_SVH
`define SMARX_CFG_SVH
// ==========================================================
// register offsets
`define SMARX_ADDR_STREAM 8'h08
`define SMARX_ADDR_AUX 8'h09
`define SMARX_ADDR_RXCFG1 8'h0a
// ==========================================================
// reset values
`define SMARX_RST_STREAM 8'h00
`define SMARX_RST_AUX 8'h04
`define SMARX_RST_RXCFG1 8'h00
// ==========================================================
// field positions, stream register
`define SMARX_SCF_LSB 5
`define SMARX_SCP_LSB 3
`define SMARX_STX_LSB 0
// field positions, auxiliary register
`define SMARX_NO_CRC_BIT 7
`define SMARX_CRC_FIFO_BIT 6
`define SMARX_MOD_BIT 5
`define SMARX_FD_BIT 4
`define SMARX_OOK_TRI_BIT 3
`define SMARX_TOL_BIT 2
`define SMARX_NFCN_LSB 0
// field positions, receiver configuration one
`define SMARX_CHSEL_BIT 7
`define SMARX_AMD_BIT 6
`define SMARX_FILT_LSB 0
`endif

// *** include/smarx_pkg.sv ***
package smarx_pkg;
   // ==========================================================
   // enumerations
   typedef enum logic [1:0] {
      SMARX_RST_IDLE = 2'b00,
      SMARX_RST_LOAD = 2'b01
   } smarx_def_state_t;
   typedef enum logic {
      SMARX_MOD_OOK = 1'b0,
      SMARX_MOD_AM = 1'b1
   } smarx_mod_t;
   typedef logic [7:0] smarx_byte_t;
endpackage

// *** include/smarx_bus_if.sv ***
`timescale 1ns/10ps
// ==========================================================
// register port between top and register cell
interface smarx_bus_if;
   logic wr_en;
   logic load_def;
   logic [7:0] wdata;
   modport ctl (output wr_en, output load_def, output wdata);
   modport reg_side (input wr_en, input load_def, input wdata);
endinterface

// *** hdl/smarx_reg8.sv ***
`timescale 1ns/10ps
// ==========================================================
// one 8-bit register with write and set-default load
module smarx_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // control
   smarx_bus_if.reg_side bus,
   // value
   output logic [7:0] val_out
);
   // default load beats a write in the same cycle
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         val_out <= RESET_VAL;
      end else if (bus.load_def) begin
         val_out <= RESET_VAL;
      end else if (bus.wr_en) begin
         val_out <= bus.wdata;
      end
   end
endmodule // smarx_reg8

// *** hdl/smarx_div.sv ***
`timescale 1ns/10ps
// ==========================================================
// power-of-two divider of a carrier-rate enable
module smarx_div #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // rate
   input wire logic tick_in,
   input wire logic [2:0] log2_in,
   // pulse
   output logic pulse_out
);
   logic [WIDTH-1:0] cnt_q;
   wire [WIDTH-1:0] mask = WIDTH'((1 << log2_in) - 1);
   wire wrap = ((cnt_q & mask) == mask);
   // counter wraps at the selected period
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= '0;
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= tick_in & wrap;
         if (tick_in) begin
            cnt_q <= wrap ? '0 : WIDTH'(cnt_q + 1'b1);
         end
      end
   end
endmodule // smarx_div

// *** verification/smarx_regs_tb.sv ***
`timescale 1ns/10ps
`include "smarx_cfg.svh"
// ==========================================================
// self-checking bench for the stream, auxiliary and receiver registers
module smarx_regs_tb;
   // ==========================================================
   // stimulus and observed outputs
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0, rd_in = 1'b0, set_default_in = 1'b0;
   logic analog_preset_in = 1'b0, preset_mod_am_in = 1'b0, bpsk_mode_in = 1'b0;
   logic tx_reqa_wupa_in = 1'b0, anticoll_in = 1'b0, ook_active_in = 1'b0;
   logic am_en_in = 1'b0, pm_en_in = 1'b0, very_high_bit_rate_in = 1'b0;
   logic carrier_tick_in = 1'b1;
   logic [7:0] rdata_out;
   logic [3:0] sub_carrier_log2_out, pulses_out;
   logic pulse_cfg_bad_out, freq_cfg_bad_out, tx_period_bad_out, tx_mod_tick_out;
   logic rx_crc_check_out, rx_crc_to_fifo_out, modulation_type_sel_out;
   logic field_detector_enable_out, rf_output_driver_oe_b_out, rx_tolerant_out;
   logic [1:0] nfc_n_out;
   logic rx_channel_select_out, am_ch_on_out, pm_ch_on_out, am_mixer_out;
   logic [5:0] filter_cfg_out;
   int n_mismatch = 0;
   int checked = 0;
   int gap;

   // 25 ns clock; carrier tick held high so long divisions stay short
   always #12.5 clk_in = ~clk_in;

   smarx_regs i_smarx_regs (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .set_default_in(set_default_in),
      .analog_preset_in(analog_preset_in), .preset_mod_am_in(preset_mod_am_in),
      .bpsk_mode_in(bpsk_mode_in), .tx_reqa_wupa_in(tx_reqa_wupa_in),
      .anticoll_in(anticoll_in), .ook_active_in(ook_active_in), .am_en_in(am_en_in),
      .pm_en_in(pm_en_in), .very_high_bit_rate_in(very_high_bit_rate_in),
      .carrier_tick_in(carrier_tick_in), .sub_carrier_log2_out(sub_carrier_log2_out),
      .pulses_out(pulses_out), .pulse_cfg_bad_out(pulse_cfg_bad_out),
      .freq_cfg_bad_out(freq_cfg_bad_out), .tx_period_bad_out(tx_period_bad_out),
      .tx_mod_tick_out(tx_mod_tick_out), .rx_crc_check_out(rx_crc_check_out),
      .rx_crc_to_fifo_out(rx_crc_to_fifo_out),
      .modulation_type_sel_out(modulation_type_sel_out),
      .field_detector_enable_out(field_detector_enable_out),
      .rf_output_driver_oe_b_out(rf_output_driver_oe_b_out),
      .rx_tolerant_out(rx_tolerant_out), .nfc_n_out(nfc_n_out),
      .rx_channel_select_out(rx_channel_select_out), .am_ch_on_out(am_ch_on_out),
      .pm_ch_on_out(pm_ch_on_out), .am_mixer_out(am_mixer_out),
      .filter_cfg_out(filter_cfg_out)
   );

   // ==========================================================
   // bus tasks and comparison
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      check(what, rdata_out, exp);
   endtask
   // decoded outputs lag a register change by one cycle, margin added
   task automatic settle();
      repeat (3) @(posedge clk_in);
      #1;
   endtask
   // cycles between two modulator ticks, bounded so a dead divider cannot hang
   task automatic tick_gap(output int n);
      n = 0;
      while (tx_mod_tick_out !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (tx_mod_tick_out !== 1'b1 && n < 300);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog: the sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      report_and_stop();
   end

   // ==========================================================
   // test sequence
   initial begin
      repeat (20) @(posedge clk_in);
      #1;
      check("tolerant at reset", rx_tolerant_out, 8'h01);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd(`SMARX_ADDR_STREAM, 8'h00, "stream default");
      rd(`SMARX_ADDR_AUX, 8'h04, "aux default");
      rd(`SMARX_ADDR_RXCFG1, 8'h00, "rxcfg default");
      rd(8'h0b, 8'h00, "unmapped read");
      $display("test reset done");
      // sub-carrier then bpsk frequency and pulse codes
      for (int i = 0; i < 4; i++) begin
         wr(`SMARX_ADDR_STREAM, 8'((i << 5) | (i << 3)));
         settle();
         check("sub log2", sub_carrier_log2_out, 8'(6 - i));
         check("pulses", pulses_out, 8'(1 << i));
         check("pulse bad", pulse_cfg_bad_out, 8'(i == 0));
      end
      @(posedge clk_in);
      bpsk_mode_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(`SMARX_ADDR_STREAM, 8'(i << 5));
         settle();
         if (i < 3) check("bpsk log2", sub_carrier_log2_out, 8'(4 - i));
         check("freq bad", freq_cfg_bad_out, 8'(i == 3));
         check("bpsk pulse bad", pulse_cfg_bad_out, 8'h00);
      end
      $display("test frequency done");
      // modulator period for every code, 111 stops the ticks
      for (int i = 0; i < 7; i++) begin
         wr(`SMARX_ADDR_STREAM, 8'(i));
         settle();
         tick_gap(gap);
         check("tx period", 8'(gap), 8'(1 << (7 - i)));
      end
      wr(`SMARX_ADDR_STREAM, 8'h07);
      settle();
      check("stx bad", tx_period_bad_out, 8'h01);
      tick_gap(gap);
      check("no tick", 8'(gap >= 300), 8'h01);
      $display("test tx period done");
      // crc handling
      wr(`SMARX_ADDR_AUX, 8'h80);
      settle();
      check("crc off", rx_crc_check_out, 8'h00);
      wr(`SMARX_ADDR_AUX, 8'h40);
      settle();
      check("crc on", rx_crc_check_out, 8'h01);
      check("crc fifo", rx_crc_to_fifo_out, 8'h01);
      @(posedge clk_in);
      tx_reqa_wupa_in <= 1'b1;
      settle();
      check("reqa skip", rx_crc_check_out, 8'h00);
      check("fifo skip", rx_crc_to_fifo_out, 8'h00);
      @(posedge clk_in);
      tx_reqa_wupa_in <= 1'b0;
      anticoll_in <= 1'b1;
      settle();
      check("anticoll skip", rx_crc_check_out, 8'h00);
      @(posedge clk_in);
      anticoll_in <= 1'b0;
      $display("test crc done");
      // modulation type, preset and write override, detector, tristate
      wr(`SMARX_ADDR_AUX, 8'h38);
      settle();
      check("mod am", modulation_type_sel_out, 8'h01);
      check("fd on", field_detector_enable_out, 8'h01);
      check("tolerant off", rx_tolerant_out, 8'h00);
      @(posedge clk_in);
      ook_active_in <= 1'b1;
      settle();
      check("am drives", rf_output_driver_oe_b_out, 8'h00);
      @(posedge clk_in);
      analog_preset_in <= 1'b1;
      @(posedge clk_in);
      analog_preset_in <= 1'b0;
      settle();
      check("preset ook", modulation_type_sel_out, 8'h00);
      check("ook float", rf_output_driver_oe_b_out, 8'h01);
      @(posedge clk_in);
      ook_active_in <= 1'b0;
      settle();
      check("idle drives", rf_output_driver_oe_b_out, 8'h00);
      // preset to am, then a same-cycle write of ook wins over the preset
      @(posedge clk_in);
      preset_mod_am_in <= 1'b1;
      analog_preset_in <= 1'b1;
      @(posedge clk_in);
      analog_preset_in <= 1'b0;
      settle();
      check("preset am", modulation_type_sel_out, 8'h01);
      @(posedge clk_in);
      addr_in <= `SMARX_ADDR_AUX;
      wdata_in <= 8'h00;
      wr_in <= 1'b1;
      analog_preset_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      analog_preset_in <= 1'b0;
      settle();
      check("write wins", modulation_type_sel_out, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(`SMARX_ADDR_AUX, 8'(i));
         settle();
         check("nfc n", nfc_n_out, 8'(i));
      end
      $display("test auxiliary done");
      // receive channel and demodulator
      wr(`SMARX_ADDR_RXCFG1, 8'h80);
      @(posedge clk_in);
      am_en_in <= 1'b1;
      pm_en_in <= 1'b1;
      settle();
      check("rx_channel_select pm", rx_channel_select_out, 8'h01);
      check("both on", 8'({am_ch_on_out, pm_ch_on_out}), 8'h03);
      check("peak", am_mixer_out, 8'h00);
      @(posedge clk_in);
      very_high_bit_rate_in <= 1'b1;
      settle();
      check("very_high_bit_rate mixer", am_mixer_out, 8'h01);
      wr(`SMARX_ADDR_RXCFG1, 8'h7f);
      rd(`SMARX_ADDR_RXCFG1, 8'h7f, "rxcfg readback");
      check("filter", filter_cfg_out, 8'h3f);
      @(posedge clk_in);
      pm_en_in <= 1'b0;
      settle();
      check("am only", 8'({am_ch_on_out, pm_ch_on_out}), 8'h02);
      wr(`SMARX_ADDR_RXCFG1, 8'h80);
      @(posedge clk_in);
      am_en_in <= 1'b0;
      pm_en_in <= 1'b1;
      settle();
      check("pm only", 8'({am_ch_on_out, pm_ch_on_out}), 8'h01);
      $display("test receiver done");
      // set-default beats a same-cycle write
      wr(`SMARX_ADDR_STREAM, 8'h7f);
      @(posedge clk_in);
      set_default_in <= 1'b1;
      addr_in <= `SMARX_ADDR_AUX;
      wdata_in <= 8'h55;
      wr_in <= 1'b1;
      @(posedge clk_in);
      set_default_in <= 1'b0;
      wr_in <= 1'b0;
      rd(`SMARX_ADDR_STREAM, 8'h00, "stream reload");
      rd(`SMARX_ADDR_AUX, 8'h04, "aux reload");
      rd(`SMARX_ADDR_RXCFG1, 8'h00, "rxcfg reload");
      $display("test set default done");
      report_and_stop();
   end
endmodule // smarx_regs_tb
